// ==== mops_pkg.sv ====
package mops_pkg;
    // output route mode encodings
    localparam logic [2:0] MODE_STEER = 3'h0;
    localparam logic [2:0] MODE_PUSHPULL = 3'h1;
    localparam logic [2:0] MODE_HALFBR = 3'h2;
    localparam logic [2:0] MODE_REVERSE = 3'h4;
    localparam logic [2:0] MODE_FORWARD = 3'h5;
    localparam logic [2:0] MODE_SCAN = 3'h6;
    localparam int NUM_PINS = 6;
    localparam int DT_W = 6;
    // values after reset
    localparam logic [5:0] EN_RESET = 6'h01;
    localparam logic [2:0] MODE_RESET = 3'h0;
    localparam logic [5:0] SCAN_FIRST = 6'h01;
    localparam logic [5:0] DT_ZERO = 6'h00;
    // pin positions
    localparam int PIN_A = 0;
    localparam int PIN_B = 1;
    localparam int PIN_C = 2;
    localparam int PIN_D = 3;
    localparam int PIN_E = 4;
    localparam int PIN_F = 5;
endpackage

// ==== mops_steer.sv ====
`timescale 1ns/1ns
module mops_steer (
    input wire logic i_clk, // 100 MHz unit clock
    input wire logic i_rst, // async reset, active high
    input wire logic i_ce, // clock enable, freezes all state when low
    input wire logic i_module_on, // module enable
    input wire logic i_compare, // compare/pwm signal
    input wire logic i_period_sync, // selected sync source, period boundary pulse
    input wire logic i_trig_event, // time base triggered pulse
    input wire logic [2:0] i_output_route_mode, // output mode field
    input wire logic [5:0] i_pin_drive_enables, // pin enables, bit 0 is pin a
    input wire logic [5:0] i_dead_time_count, // dead time in cycles
    input wire logic i_enable_change_sync, // apply enable changes on sync only
    input wire logic i_drive_on_trigger, // tristate pins until triggered
    input wire logic i_triggered_operation_enable, // triggered mode
    input wire logic i_trigger_status_flag, // time base has been triggered
    output logic [5:0] o_pin_data, // pin levels, bit 0 is pin a
    output logic [5:0] o_pin_oe, // pin drive enables, high drives
    output logic [5:0] o_pin_claim // module owns the pin
);

    // ****************************************
    // enable synchronisation
    // ****************************************
    logic [5:0] en_r;
    logic [5:0] en_nxt;
    assign en_nxt = (!i_enable_change_sync || i_period_sync) ? i_pin_drive_enables : en_r;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            en_r <= mops_pkg::EN_RESET;
        end else if (i_ce) begin
            en_r <= en_nxt;
        end
    end

    // ****************************************
    // dead-time generator for half-bridge
    // ****************************************
    logic cmp_d_r;
    logic [5:0] hb_cnt_r;
    logic [5:0] hb_cnt_nxt;
    logic hb_true_r;
    logic hb_comp_r;
    logic hb_edge;
    logic hb_zero_dt;
    assign hb_edge = i_compare != cmp_d_r;
    assign hb_zero_dt = i_dead_time_count == mops_pkg::DT_ZERO;
    // the edge reloads the counter; both outputs idle inactive while it runs
    assign hb_cnt_nxt = hb_edge ? i_dead_time_count :
        (hb_cnt_r != mops_pkg::DT_ZERO) ? hb_cnt_r - 6'h01 : hb_cnt_r;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cmp_d_r <= 1'b0;
            hb_cnt_r <= mops_pkg::DT_ZERO;
            hb_true_r <= 1'b0;
            hb_comp_r <= 1'b0;
        end else if (i_ce) begin
            cmp_d_r <= i_compare;
            hb_cnt_r <= hb_cnt_nxt;
            if (hb_zero_dt) begin
                hb_true_r <= i_compare;
                hb_comp_r <= !i_compare;
            end else if (hb_edge) begin
                hb_true_r <= 1'b0;
                hb_comp_r <= 1'b0;
            end else if (hb_cnt_r == 6'h01) begin
                hb_true_r <= cmp_d_r;
                hb_comp_r <= !cmp_d_r;
            end
        end
    end

    // ****************************************
    // brushed dc direction control
    // ****************************************
    logic is_bdc;
    logic dir_r;
    logic dir_pend_r;
    logic bdc_blank_r;
    logic [5:0] bdc_cnt_r;
    logic mode_lsb_r;
    logic dir_toggle;
    logic dir_apply;
    assign is_bdc = i_output_route_mode[2:1] == mops_pkg::MODE_REVERSE[2:1];
    assign dir_toggle = is_bdc && (i_output_route_mode[0] != mode_lsb_r);
    assign dir_apply = (dir_pend_r || dir_toggle) && i_period_sync;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            mode_lsb_r <= 1'b1;
            dir_r <= 1'b1;
            dir_pend_r <= 1'b0;
            bdc_blank_r <= 1'b0;
            bdc_cnt_r <= mops_pkg::DT_ZERO;
        end else if (i_ce) begin
            mode_lsb_r <= i_output_route_mode[0];
            if (dir_toggle) begin
                bdc_cnt_r <= i_dead_time_count;
            end else if (bdc_blank_r && bdc_cnt_r != mops_pkg::DT_ZERO) begin
                bdc_cnt_r <= bdc_cnt_r - 6'h01;
            end
            if (dir_apply) begin
                dir_pend_r <= 1'b0;
                dir_r <= i_output_route_mode[0];
                bdc_blank_r <= !hb_zero_dt;
            end else begin
                if (dir_toggle) begin
                    dir_pend_r <= 1'b1;
                end
                if (bdc_blank_r && bdc_cnt_r <= 6'h01) begin
                    bdc_blank_r <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // push-pull phase and scan sequence
    // ****************************************
    logic pp_phase_r;
    logic [5:0] scan_r;
    logic [5:0] scan_nxt;
    logic [11:0] scan_dbl;
    logic [5:0] scan_rot;
    logic scan_step;
    assign scan_step = i_trig_event || i_period_sync;

    // next enabled pin above current one, wrapping around
    always_comb begin
        scan_rot = 6'h00;
        scan_dbl = {en_r, en_r} & ~({6'h00, scan_r} | {6'h00, scan_r - 6'h01} |
            {scan_r, 6'h00} & 12'h000);
        for (int k = 11; k >= 1; k--) begin
            if (scan_dbl[k] && ((12'h001 << k) > {6'h00, scan_r})) begin
                scan_rot = 6'h00;
            end
        end
        scan_rot = 6'h00;
        for (int k = 11; k >= 1; k--) begin
            if (scan_dbl[k] && ((12'h001 << k) > {6'h00, scan_r})) begin
                scan_rot = (k >= mops_pkg::NUM_PINS) ?
                    6'(1 << (k - mops_pkg::NUM_PINS)) : 6'(1 << k);
            end
        end
        scan_nxt = (scan_rot == 6'h00) ? scan_r : scan_rot;
    end

    logic [5:0] first_en;
    assign first_en = en_r & (~en_r + 6'h01);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pp_phase_r <= 1'b0;
            scan_r <= mops_pkg::SCAN_FIRST;
        end else if (i_ce) begin
            if (!i_module_on) begin
                scan_r <= mops_pkg::SCAN_FIRST;
                pp_phase_r <= 1'b0;
            end else begin
                if (i_period_sync) begin
                    pp_phase_r <= !pp_phase_r;
                end
                if ((scan_r & en_r) == 6'h00) begin
                    scan_r <= first_en;
                end else if (scan_step) begin
                    scan_r <= scan_nxt;
                end
            end
        end
    end

    // ****************************************
    // output routing
    // ****************************************
    logic [5:0] data_sel;
    logic [5:0] drv_sel;
    logic [5:0] bdc_data;
    logic [1:0] hb_pair;
    logic [1:0] pp_pair;
    logic gate_trig;
    assign hb_pair = {hb_comp_r, hb_true_r};
    assign pp_pair = pp_phase_r ? {i_compare, 1'b0} : {1'b0, i_compare};
    // forward: a pwm, d active; reverse: c pwm, b active; e/f stay low
    assign bdc_data = bdc_blank_r ? 6'h00 :
        dir_r ? {1'b0, 1'b0, 1'b1, 1'b0, 1'b0, i_compare}
              : {1'b0, 1'b0, 1'b0, i_compare, 1'b1, 1'b0};
    assign gate_trig = i_triggered_operation_enable && i_drive_on_trigger;

    always_comb begin
        drv_sel = 6'h3f;
        case (i_output_route_mode)
            mops_pkg::MODE_STEER: data_sel = {6{i_compare}};
            mops_pkg::MODE_PUSHPULL: data_sel = {pp_pair, pp_pair, pp_pair};
            mops_pkg::MODE_HALFBR: data_sel = {hb_pair, hb_pair, hb_pair};
            mops_pkg::MODE_REVERSE, mops_pkg::MODE_FORWARD: data_sel = bdc_data;
            mops_pkg::MODE_SCAN: begin
                data_sel = scan_r & {6{i_compare}};
                drv_sel = gate_trig ? scan_r : 6'h3f;
            end
            default: data_sel = 6'h00;
        endcase
        if (gate_trig && !i_trigger_status_flag) begin
            drv_sel = 6'h00;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pin_data <= 6'h00;
            o_pin_oe <= 6'h00;
            o_pin_claim <= 6'h00;
        end else if (i_ce) begin
            o_pin_data <= data_sel & en_r;
            o_pin_oe <= drv_sel & en_r;
            o_pin_claim <= en_r;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    sequence hb_steady;
        (i_output_route_mode == mops_pkg::MODE_HALFBR) && hb_zero_dt && i_ce
            && en_r[0] && en_r[1];
    endsequence

    hb_complement_a: assert property (@(posedge i_clk) disable iff (i_rst)
        hb_steady ##1 hb_steady |=> o_pin_data[1] == !o_pin_data[0])
        else $error("half-bridge pins not complementary");

    hb_replicate_a: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_output_route_mode == mops_pkg::MODE_HALFBR) && i_ce && (&en_r)
        |=> o_pin_data[3:2] == o_pin_data[1:0])
        else $error("half-bridge pairs differ");

    hb_deadband_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && hb_edge && !hb_zero_dt |=> !hb_true_r && !hb_comp_r)
        else $error("dead band not inserted");

    bdc_ef_low_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && is_bdc |=> o_pin_data[5:4] == 2'b00)
        else $error("e/f driven in brushed dc");

    bdc_fwd_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && is_bdc && dir_r && !bdc_blank_r && en_r[3] |=> o_pin_data[3])
        else $error("forward pin d not active");

    dir_sync_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && !i_period_sync |=> $stable(dir_r))
        else $error("direction changed off sync");

    scan_reset_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && !i_module_on |=> scan_r == mops_pkg::SCAN_FIRST)
        else $error("scan not reset when module off");

    trig_hiz_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && gate_trig && !i_trigger_status_flag |=> o_pin_oe == 6'h00)
        else $error("pins driven before trigger");

    en_sync_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_enable_change_sync && !i_period_sync |=> $stable(en_r))
        else $error("enable changed off sync");

    bdc_rev_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && is_bdc && !dir_r |=> !o_pin_data[0] && !o_pin_data[3])
        else $error("reverse drives pin a or d");

    bdc_blank_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && is_bdc && bdc_blank_r |=> o_pin_data[3:0] == 4'h0)
        else $error("bridge pins not blanked");

    dt_zero_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && dir_apply && hb_zero_dt |=> !bdc_blank_r)
        else $error("blanking with zero dead time");

    steer_all_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && (i_output_route_mode == mops_pkg::MODE_STEER)
        |=> o_pin_data == ({6{$past(i_compare)}} & $past(en_r)))
        else $error("steer mode output wrong");

    pp_alt_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && (i_output_route_mode == mops_pkg::MODE_PUSHPULL) && pp_phase_r
        |=> !o_pin_data[0])
        else $error("push-pull pin a active in b phase");

    scan_onehot_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && (i_output_route_mode == mops_pkg::MODE_SCAN) |=> $onehot0(o_pin_data))
        else $error("scan drives more than one pin");

    scan_move_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && i_module_on && scan_step && ((scan_r & en_r) != 6'h00)
        |=> (scan_r != $past(scan_r)) || $onehot($past(en_r)))
        else $error("scan did not advance");

    trig_off_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && !i_triggered_operation_enable |=> o_pin_oe == $past(en_r))
        else $error("drive on trigger acted untriggered");

    scan_trig_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && gate_trig && i_trigger_status_flag
        && (i_output_route_mode == mops_pkg::MODE_SCAN)
        |=> (o_pin_oe & ~$past(scan_r)) == 6'h00)
        else $error("idle scan pin driven");

    all_trig_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce && gate_trig && i_trigger_status_flag
        && (i_output_route_mode != mops_pkg::MODE_SCAN)
        |=> o_pin_oe == $past(en_r))
        else $error("enabled pin not driven after trigger");

    release_a: assert property (@(posedge i_clk) disable iff (i_rst)
        i_ce |=> (o_pin_oe & ~o_pin_claim) == 6'h00)
        else $error("released pin still driven");

endmodule

// ==== mops_bridge_model.sv ====
`timescale 1ns/1ns
// ************
// power bridge
// ************
module mops_bridge_model (
    input wire logic i_clk, // unit clock
    input wire logic i_rst, // async reset, active high
    input wire logic [5:0] i_pin_data, // module pin levels
    input wire logic [5:0] i_pin_oe, // module drive enables
    input wire logic [5:0] i_pin_claim, // module owns the pin
    output logic [5:0] o_pin_level // level seen by the switches
);
    logic [5:0] last_r;
    wire logic [5:0] drv_w = i_pin_oe & i_pin_claim;
    // a floating line must not keep its old level, so undriven pins flip each cycle
    assign o_pin_level = (drv_w & i_pin_data) | (~drv_w & ~last_r);
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            last_r <= 6'h00;
        end else begin
            last_r <= o_pin_level;
        end
    end
endmodule

// ==== multi_output_pwm_steering_tb_top.sv ====
`timescale 1ns/1ns
module multi_output_pwm_steering_tb_top;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic mon = 1'b1;
    logic ce = 1'b1;
    logic cmp = 1'b1;
    logic psy = 1'b0;
    logic trg = 1'b0;
    logic [2:0] mode = 3'h0;
    logic [5:0] en = 6'h3F;
    logic [5:0] dt = 6'h00;
    logic ens = 1'b0;
    logic dot = 1'b0;
    logic toe = 1'b0;
    logic tsf = 1'b0;
    logic [5:0] pdat;
    logic [5:0] poe;
    logic [5:0] pcl;
    logic [5:0] plev;
    int n_errors = 0;
    int tests_run = 0;
    always #5 clk = ~clk;
    mops_steer dut_u (.i_clk(clk), .i_rst(rst), .i_ce(ce), .i_module_on(mon),
        .i_compare(cmp), .i_period_sync(psy), .i_trig_event(trg),
        .i_output_route_mode(mode), .i_pin_drive_enables(en), .i_dead_time_count(dt),
        .i_enable_change_sync(ens), .i_drive_on_trigger(dot),
        .i_triggered_operation_enable(toe), .i_trigger_status_flag(tsf),
        .o_pin_data(pdat), .o_pin_oe(poe), .o_pin_claim(pcl));
    mops_bridge_model br_u (.i_clk(clk), .i_rst(rst), .i_pin_data(pdat), .i_pin_oe(poe),
        .i_pin_claim(pcl), .o_pin_level(plev));
    task step(input int n);
        repeat (n) @(negedge clk);
    endtask
    task chk(input logic [5:0] got, input logic [5:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task sync;
        psy = 1'b1;
        step(1);
        psy = 1'b0;
    endtask
    task trig;
        trg = 1'b1;
        step(1);
        trg = 1'b0;
    endtask
    task print_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #20000;
        n_errors++;
        print_verdict;
    end
    // ******************
    // stimulus and checks
    // ******************
    initial begin
        step(10);
        chk(pdat | poe | pcl, 6'h00);
        rst = 1'b0;
        step(4);
        chk(pdat, 6'h3F);
        chk(poe, 6'h3F);
        chk(plev, 6'h3F);
        cmp = 1'b0;
        step(3);
        chk(pdat, 6'h00);
        en = 6'h05;
        step(4);
        chk(pcl, 6'h05);
        $display("test steer done");
        mode = 3'h2;
        en = 6'h3F;
        cmp = 1'b1;
        step(5);
        chk(pdat, 6'h15);
        cmp = 1'b0;
        step(5);
        chk(pdat, 6'h2A);
        dt = 6'h04;
        step(2);
        cmp = 1'b1;
        step(3);
        chk(pdat, 6'h00);
        step(6);
        chk(pdat, 6'h15);
        $display("test half bridge done");
        dt = 6'h00;
        mode = 3'h5;
        step(5);
        chk(pdat, 6'h09);
        cmp = 1'b0;
        step(3);
        chk(pdat, 6'h08);
        mode = 3'h4;
        cmp = 1'b1;
        step(4);
        chk(pdat, 6'h09);
        sync;
        step(4);
        chk(pdat, 6'h06);
        dt = 6'h14;
        mode = 3'h5;
        step(2);
        sync;
        step(3);
        chk({2'b00, pdat[3:0]}, 6'h00);
        step(25);
        chk(pdat, 6'h09);
        $display("test brushed dc done");
        dt = 6'h00;
        mode = 3'h6;
        en = 6'h13;
        mon = 1'b0;
        step(3);
        mon = 1'b1;
        step(3);
        chk(pdat, 6'h01);
        trig;
        step(3);
        chk(pdat, 6'h02);
        sync;
        step(3);
        chk(pdat, 6'h10);
        sync;
        step(3);
        chk(pdat, 6'h01);
        trig;
        step(3);
        mon = 1'b0;
        step(3);
        mon = 1'b1;
        step(3);
        chk(pdat, 6'h01);
        $display("test scan done");
        toe = 1'b1;
        dot = 1'b1;
        step(3);
        chk(poe, 6'h00);
        tsf = 1'b1;
        step(3);
        chk(poe, 6'h01);
        mode = 3'h0;
        step(3);
        chk(poe, 6'h13);
        toe = 1'b0;
        tsf = 1'b0;
        step(3);
        chk(poe, 6'h13);
        dot = 1'b0;
        $display("test trigger done");
        ens = 1'b1;
        en = 6'h03;
        step(4);
        chk(pcl, 6'h13);
        sync;
        step(3);
        chk(pcl, 6'h03);
        ens = 1'b0;
        en = 6'h0F;
        step(3);
        chk(pcl, 6'h0F);
        $display("test enable sync done");
        mon = 1'b0;
        step(2);
        mon = 1'b1;
        mode = 3'h1;
        en = 6'h3F;
        cmp = 1'b1;
        step(3);
        chk(pdat, 6'h15);
        sync;
        step(3);
        chk(pdat, 6'h2A);
        $display("test push pull done");
        mode = 3'h0;
        step(3);
        ce = 1'b0;
        cmp = 1'b0;
        step(3);
        chk(pdat, 6'h3F);
        ce = 1'b1;
        step(2);
        chk(pdat, 6'h00);
        $display("test clock enable done");
        print_verdict;
    end
endmodule
